// >>> core/cctmr_top.sv
`default_nettype none

// What this block does
// - Irq only when flag and enable set
// - Timer held in reset while run off
// - Edge select: one rising, zero falling
// - Compare match copies level bit to pin
// - Capture flag set; cleared via status, capture low
// - Compare flag set; cleared via status, compare low
// - Overflow flag on wrap; cleared via status, counter low
// - Status access arms, associated access clears
// - Status access then counter high leaves overflow armed
// - Alternate counter reads never touch overflow flag
// - Runs in wait; enabled irq wakes
// - Stop freezes counter; resume from held value
// - Reset out of stop forces FFFC
// - Stop edge arms capture, shown on wake
// - Reset discards capture taken during stop
// - Status read only, three flags
// - Counter advances every four clocks
// - High read freezes low byte buffer
// - Compare high write blocks match until low
// - Capture high read blocks run-mode transfer until low; stop wake transfer ignores it
module cctmr_top (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic capture_pin,
	output logic compare_pin,
	output logic timer_irq,
	output logic wake_req
);
	import cctmr_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic idx_mapped(input logic [5:0] idx);
		idx_mapped = (idx >= IDX_CTRL) && (idx <= IDX_ALT_LO);
	endfunction : idx_mapped

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	cctmr_ctrl_s ctrl_reg;
	cctmr_flags_s flags_reg;
	cctmr_flags_s arm_reg;
	cctmr_rd_e rd_state_reg;
	logic [15:0] counter_reg;
	logic [1:0] presc_reg;
	logic [15:0] compare_reg;
	logic [15:0] capture_reg;
	logic [15:0] stop_cap_reg;
	logic stop_pend_reg;
	logic stop_q_reg;
	logic cap_s1_reg, cap_s2_reg, cap_s3_reg;
	logic [7:0] cnt_buf_reg;
	logic cnt_frozen_reg;
	logic cap_inhibit_reg;
	logic cmp_inhibit_reg;
	logic aw_held_reg, w_held_reg;
	logic [5:0] aw_idx_reg;
	logic [7:0] w_byte_reg;
	logic w_lane_reg;
	logic [7:0] rd_mux;

	// ------------------------------------------------------------
	// Bus access decode
	// ------------------------------------------------------------
	logic rd_fire, wr_fire;
	logic [5:0] rd_idx;
	logic tick, run, edge_seen, match, stop_exit;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign rd_idx = s_axi_araddr[7:2];

	// Access of either kind counts for the two-step flag clear
	logic acc_status, acc_cap_lo, acc_cmp_lo, acc_cnt_lo;
	assign acc_status = (rd_fire && rd_idx == IDX_STATUS) || (wr_fire && aw_idx_reg == IDX_STATUS);
	assign acc_cap_lo = (rd_fire && rd_idx == IDX_CAP_LO) || (wr_fire && aw_idx_reg == IDX_CAP_LO);
	assign acc_cmp_lo = (rd_fire && rd_idx == IDX_CMP_LO) || (wr_fire && aw_idx_reg == IDX_CMP_LO);
	assign acc_cnt_lo = (rd_fire && rd_idx == IDX_CNT_LO) || (wr_fire && aw_idx_reg == IDX_CNT_LO);

	// ------------------------------------------------------------
	// Write channels
	// ------------------------------------------------------------
	// Address and data are taken in either order, held until both are in
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held_reg <= 1'b0;
			aw_idx_reg <= 6'h00;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			aw_idx_reg <= s_axi_awaddr[7:2];
			s_axi_awready <= 1'b0;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			w_held_reg <= 1'b0;
			w_byte_reg <= 8'h00;
			w_lane_reg <= 1'b0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			w_byte_reg <= s_axi_wdata[7:0];
			w_lane_reg <= s_axi_wstrb[0];
			s_axi_wready <= 1'b0;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	// Response one cycle after both halves are in
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= idx_mapped(aw_idx_reg) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	logic wr_byte;
	assign wr_byte = wr_fire && w_lane_reg;

	// Control register; status stays read only, writes there are dropped
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_byte && aw_idx_reg == IDX_CTRL) begin
			ctrl_reg <= {w_byte_reg[7:4], 2'b00, w_byte_reg[1:0]};
		end
	end

	// Compare bytes written independently; high write blocks matching
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			compare_reg <= CMP_RESET;
			cmp_inhibit_reg <= 1'b0;
		end else if (wr_byte && aw_idx_reg == IDX_CMP_HI) begin
			compare_reg[15:8] <= w_byte_reg;
			cmp_inhibit_reg <= 1'b1;
		end else if (wr_byte && aw_idx_reg == IDX_CMP_LO) begin
			compare_reg[7:0] <= w_byte_reg;
			cmp_inhibit_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	// Low byte of a counter returns the frozen buffer after a high read
	always_comb begin
		rd_mux = 8'h00;
		case (rd_idx)
			IDX_CTRL: rd_mux = ctrl_reg;
			IDX_STATUS: rd_mux = {flags_reg, 5'h00};
			IDX_CAP_HI: rd_mux = capture_reg[15:8];
			IDX_CAP_LO: rd_mux = capture_reg[7:0];
			IDX_CMP_HI: rd_mux = compare_reg[15:8];
			IDX_CMP_LO: rd_mux = compare_reg[7:0];
			IDX_CNT_HI, IDX_ALT_HI: rd_mux = counter_reg[15:8];
			IDX_CNT_LO, IDX_ALT_LO: rd_mux = cnt_frozen_reg ? cnt_buf_reg : counter_reg[7:0];
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_state_reg <= CCTMR_RD_IDLE;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			case (rd_state_reg)
				CCTMR_RD_IDLE: begin
					if (rd_fire) begin
						rd_state_reg <= CCTMR_RD_DATA;
						s_axi_arready <= 1'b0;
						s_axi_rvalid <= 1'b1;
						s_axi_rdata <= {24'h000000, rd_mux};
						s_axi_rresp <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
					end
				end
				CCTMR_RD_DATA: begin
					if (s_axi_rready) begin
						rd_state_reg <= CCTMR_RD_IDLE;
						s_axi_arready <= 1'b1;
						s_axi_rvalid <= 1'b0;
					end
				end
				default: rd_state_reg <= CCTMR_RD_IDLE;
			endcase
		end
	end

	// High-byte read latches low byte; repeated high reads keep it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_buf_reg <= 8'h00;
			cnt_frozen_reg <= 1'b0;
		end else if (rd_fire && (rd_idx == IDX_CNT_HI || rd_idx == IDX_ALT_HI)) begin
			if (!cnt_frozen_reg) begin
				cnt_buf_reg <= counter_reg[7:0];
			end
			cnt_frozen_reg <= 1'b1;
		end else if (rd_fire && (rd_idx == IDX_CNT_LO || rd_idx == IDX_ALT_LO)) begin
			cnt_frozen_reg <= 1'b0;
		end
	end

	// Capture high read blocks run-mode transfers until the low byte is read; the stop-wake transfer ignores it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cap_inhibit_reg <= 1'b0;
		end else if (rd_fire && rd_idx == IDX_CAP_HI) begin
			cap_inhibit_reg <= 1'b1;
		end else if (rd_fire && rd_idx == IDX_CAP_LO) begin
			cap_inhibit_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Counter and prescaler
	// ------------------------------------------------------------
	assign run = ctrl_reg.timer_run;
	assign tick = run && !stop_mode && presc_reg == PRESC_LAST;

	// Timer off holds the reset condition; stop just freezes counter and prescaler
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			counter_reg <= CNT_RESET;
			presc_reg <= 2'h0;
		end else if (!run) begin
			counter_reg <= CNT_RESET;
			presc_reg <= 2'h0;
		end else if (!stop_mode) begin
			presc_reg <= presc_reg + 2'h1;
			if (tick) begin
				counter_reg <= counter_reg + 16'h0001;
			end
		end
	end

	// Evaluated once per count value, on its first cycle
	assign match = run && !stop_mode && presc_reg == 2'h0 && !cmp_inhibit_reg
		&& counter_reg == compare_reg;

	// Level is copied on every match, whatever the flag holds
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			compare_pin <= 1'b0;
		end else if (match) begin
			compare_pin <= ctrl_reg.compare_out_level;
		end
	end

	// ------------------------------------------------------------
	// Capture input
	// ------------------------------------------------------------
	// Two-stage synchroniser, third stage only for edge detection
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cap_s1_reg <= 1'b0;
			cap_s2_reg <= 1'b0;
			cap_s3_reg <= 1'b0;
		end else begin
			cap_s1_reg <= capture_pin;
			cap_s2_reg <= cap_s1_reg;
			cap_s3_reg <= cap_s2_reg;
		end
	end

	assign edge_seen = ctrl_reg.capture_edge_sel ? (cap_s2_reg && !cap_s3_reg)
		: (!cap_s2_reg && cap_s3_reg);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stop_q_reg <= 1'b0;
		end else begin
			stop_q_reg <= stop_mode;
		end
	end
	assign stop_exit = stop_q_reg && !stop_mode;

	// Only the first edge in stop is kept; reset wipes it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stop_pend_reg <= 1'b0;
			stop_cap_reg <= CAP_RESET;
		end else if (!run || stop_exit) begin
			stop_pend_reg <= 1'b0;
		end else if (stop_mode && edge_seen && !stop_pend_reg) begin
			stop_pend_reg <= 1'b1;
			stop_cap_reg <= counter_reg;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			capture_reg <= CAP_RESET;
		end else if (stop_exit && stop_pend_reg) begin
			capture_reg <= stop_cap_reg;
		end else if (run && !stop_mode && edge_seen && !cap_inhibit_reg) begin
			capture_reg <= counter_reg;
		end
	end

	// ------------------------------------------------------------
	// Flags and two-step clear
	// ------------------------------------------------------------
	logic set_cap, set_cmp, set_ovf;
	assign set_cap = (run && !stop_mode && edge_seen) || (stop_exit && stop_pend_reg);
	assign set_cmp = match;
	assign set_ovf = tick && counter_reg == CNT_MAX;

	// Set wins over a clear landing in the same cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_reg <= FLAGS_RESET;
		end else if (!run) begin
			flags_reg <= FLAGS_RESET;
		end else begin
			if (set_cap) flags_reg.capture_flag <= 1'b1;
			else if (arm_reg.capture_flag && acc_cap_lo) flags_reg.capture_flag <= 1'b0;
			if (set_cmp) flags_reg.compare_flag <= 1'b1;
			else if (arm_reg.compare_flag && acc_cmp_lo) flags_reg.compare_flag <= 1'b0;
			if (set_ovf) flags_reg.overflow_flag <= 1'b1;
			else if (arm_reg.overflow_flag && acc_cnt_lo) flags_reg.overflow_flag <= 1'b0;
		end
	end

	// Status access arms each set flag; the arm stands through counter
	// high reads, so a stray status access plus counter read clears it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			arm_reg <= FLAGS_RESET;
		end else if (!run) begin
			arm_reg <= FLAGS_RESET;
		end else if (acc_status) begin
			arm_reg <= flags_reg;
		end else begin
			if (acc_cap_lo) arm_reg.capture_flag <= 1'b0;
			if (acc_cmp_lo) arm_reg.compare_flag <= 1'b0;
			if (acc_cnt_lo) arm_reg.overflow_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Interrupt request and wake
	// ------------------------------------------------------------
	logic irq_any;
	assign irq_any = (flags_reg.capture_flag && ctrl_reg.capture_irq_en)
		|| (flags_reg.compare_flag && ctrl_reg.compare_irq_en)
		|| (flags_reg.overflow_flag && ctrl_reg.overflow_irq_en);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_irq <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			timer_irq <= irq_any;
			wake_req <= irq_any && wait_mode;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_irq_gating: assert property (!irq_any |=> !timer_irq)
		else $error("irq raised without enabled flag");
	a_off_hold: assert property (!run |=> counter_reg == CNT_RESET && flags_reg == FLAGS_RESET)
		else $error("timer not held while off");
	a_edge_flag: assert property (run && !stop_mode && edge_seen |=> flags_reg.capture_flag)
		else $error("selected edge did not set capture flag");
	a_match_level: assert property (match |=> compare_pin == $past(ctrl_reg.compare_out_level))
		else $error("compare pin missed level");
	a_wrap_flag: assert property (set_ovf |=> flags_reg.overflow_flag && counter_reg == 16'h0000)
		else $error("wrap did not set overflow");
	a_clear_armed: assert property (run && $past(run) && $fell(flags_reg.capture_flag)
		|-> $past(arm_reg.capture_flag))
		else $error("capture flag cleared without arm");
	a_alt_safe: assert property (rd_fire && (rd_idx == IDX_ALT_HI || rd_idx == IDX_ALT_LO)
		&& flags_reg.overflow_flag && run |=> flags_reg.overflow_flag || !run)
		else $error("alternate read cleared overflow");
	a_stop_freeze: assert property (stop_mode && run ##1 stop_mode && run
		|-> $stable(counter_reg))
		else $error("counter moved in stop");
	// Switching the timer off reloads the counter, so that cycle is excused
	a_prescale_four: assert property (run && !stop_mode && $changed(counter_reg) && $past(run)
		|-> ##1 ($stable(counter_reg) || !run)[*3])
		else $error("counter advanced faster than one per four");
	a_cmp_block: assert property (cmp_inhibit_reg |=> !$rose(flags_reg.compare_flag))
		else $error("compare flag set while compare blocked");
	a_wait_wake: assert property (irq_any && wait_mode |=> wake_req)
		else $error("no wake from enabled irq in wait");

	c_capture: cover property (set_cap && !stop_exit);
	c_match: cover property (match ##1 compare_pin);
	c_ovf_clear: cover property ($fell(flags_reg.overflow_flag) && run);
	c_stop_wake: cover property (stop_exit && stop_pend_reg);

endmodule : cctmr_top

`default_nettype wire

// >>> core/cctmr_pkg.sv
`default_nettype none

package cctmr_pkg;

	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_CTRL = 6'h12;
	localparam logic [5:0] IDX_STATUS = 6'h13;
	localparam logic [5:0] IDX_CAP_HI = 6'h14;
	localparam logic [5:0] IDX_CAP_LO = 6'h15;
	localparam logic [5:0] IDX_CMP_HI = 6'h16;
	localparam logic [5:0] IDX_CMP_LO = 6'h17;
	localparam logic [5:0] IDX_CNT_HI = 6'h18;
	localparam logic [5:0] IDX_CNT_LO = 6'h19;
	localparam logic [5:0] IDX_ALT_HI = 6'h1A;
	localparam logic [5:0] IDX_ALT_LO = 6'h1B;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [15:0] CNT_RESET = 16'hFFFC;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CMP_RESET = 16'h0000;
	localparam logic [15:0] CAP_RESET = 16'h0000;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] PRESC_LAST = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Field layouts
	// ------------------------------------------------------------
	typedef struct packed {
		logic capture_irq_en;
		logic compare_irq_en;
		logic overflow_irq_en;
		logic timer_run;
		logic [1:0] spare;
		logic capture_edge_sel;
		logic compare_out_level;
	} cctmr_ctrl_s;

	typedef struct packed {
		logic capture_flag;
		logic compare_flag;
		logic overflow_flag;
	} cctmr_flags_s;

	localparam cctmr_flags_s FLAGS_RESET = 3'h0;

	// Which phase the read channel is in: waiting for an address or holding data
	typedef enum logic [1:0] {
		CCTMR_RD_IDLE = 2'b00,
		CCTMR_RD_DATA = 2'b01
	} cctmr_rd_e;

endpackage : cctmr_pkg

`default_nettype wire

// >>> verif/cctmr_pin_model.sv
`default_nettype none

// ------------------------------------------------------------
// Far-side pins: capture source and compare watcher
// ------------------------------------------------------------
module cctmr_pin_model (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic compare_pin,
	output var logic capture_pin,
	output var logic [7:0] cmp_rise_cnt
);
	timeunit 1ns;
	timeprecision 1ps;

	logic cmp_last;

	initial begin
		capture_pin = 1'b0;
	end

	// Count rising transitions of the compare output
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmp_last <= 1'b0;
			cmp_rise_cnt <= 8'h00;
		end else begin
			cmp_last <= compare_pin;
			if (compare_pin && !cmp_last) cmp_rise_cnt <= cmp_rise_cnt + 8'h01;
		end
	end

	// Move the capture pin, then hold it well past the synchroniser
	task automatic drive_level(input logic lvl);
		@(posedge ref_clk);
		capture_pin <= lvl;
		repeat (6) @(posedge ref_clk);
	endtask : drive_level

endmodule : cctmr_pin_model

`default_nettype wire

// >>> verif/capture_compare_timer_ctrl_tb.sv
`default_nettype none

module capture_compare_timer_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cctmr_pkg::*;

	logic ref_clk, reset_n, wait_mode, stop_mode, capture_pin, compare_pin, timer_irq, wake_req;
	logic [7:0] s_axi_awaddr, s_axi_araddr, cmp_rise_cnt;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [1:0] bresp_seen;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;

	cctmr_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wait_mode(wait_mode),
		.stop_mode(stop_mode), .capture_pin(capture_pin), .compare_pin(compare_pin),
		.timer_irq(timer_irq), .wake_req(wake_req));

	cctmr_pin_model u_pin (.ref_clk(ref_clk), .reset_n(reset_n), .compare_pin(compare_pin),
		.capture_pin(capture_pin), .cmp_rise_cnt(cmp_rise_cnt));

	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// Report and bus helpers
	// ------------------------------------------------------------
	task automatic finish_test;
		if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// Hang guard, generous against roughly 500 cycles of traffic
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 8000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [5:0] idx, input logic [7:0] d);
		logic done;
		done = 1'b0;
		@(posedge ref_clk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {4{d}};
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				bresp_seen = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [5:0] idx, output logic [7:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		@(posedge ref_clk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				d = s_axi_rdata[7:0];
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : axi_rd

	task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp, input string nm);
		logic [7:0] d;
		logic [1:0] r;
		axi_rd(idx, d, r);
		chk(nm, exp, d);
	endtask : rd_chk

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] d;
		logic [1:0] r;
		rd_chk(IDX_CTRL, 8'h00, "ctrl");
		rd_chk(IDX_STATUS, 8'h00, "status");
		rd_chk(IDX_CNT_HI, 8'hFF, "cnt_hi");
		rd_chk(IDX_CNT_LO, 8'hFC, "cnt_lo");
		axi_rd(6'h00, d, r);
		chk("unmapped_resp", {6'h00, RESP_SLVERR}, {6'h00, r});
		axi_wr(IDX_STATUS, 8'hFF);
		chk("wr_okay", {6'h00, RESP_OKAY}, {6'h00, bresp_seen});
		rd_chk(IDX_STATUS, 8'h00, "status_ro");
		axi_wr(6'h00, 8'h5A);
		chk("wr_unmapped", {6'h00, RESP_SLVERR}, {6'h00, bresp_seen});
		// Lane 0 strobe low: the access is answered but nothing is stored
		s_axi_wstrb <= 4'hE;
		axi_wr(IDX_CTRL, 8'h10);
		s_axi_wstrb <= 4'hF;
		rd_chk(IDX_CTRL, 8'h00, "ctrl_nostrb");
		// Run long enough to wrap, then switch off: all back to reset state
		axi_wr(IDX_CTRL, 8'h10);
		repeat (40) @(posedge ref_clk);
		axi_wr(IDX_CTRL, 8'h00);
		rd_chk(IDX_CNT_HI, 8'hFF, "off_cnt_hi");
		rd_chk(IDX_CNT_LO, 8'hFC, "off_cnt_lo");
		rd_chk(IDX_STATUS, 8'h00, "off_status");
	endtask : t_reset

	task automatic t_overflow;
		logic [7:0] d;
		logic [1:0] r;
		axi_wr(IDX_CMP_HI, 8'h00);
		axi_wr(IDX_CMP_LO, 8'h40);
		axi_wr(IDX_CTRL, 8'h31);
		for (int n = 0; n < 40 && timer_irq !== 1'b1; n++) @(posedge ref_clk);
		chk("timer_irq", 8'h01, {7'h00, timer_irq});
		rd_chk(IDX_STATUS, 8'h20, "ovf_status");
		rd_chk(IDX_CNT_HI, 8'h00, "cnt_hi");
		axi_rd(IDX_ALT_HI, d, r);
		axi_rd(IDX_ALT_LO, d, r);
		rd_chk(IDX_STATUS, 8'h20, "alt_status");
		@(posedge ref_clk);
		wait_mode <= 1'b1;
		for (int n = 0; n < 5 && wake_req !== 1'b1; n++) @(posedge ref_clk);
		chk("wake_req", 8'h01, {7'h00, wake_req});
		wait_mode <= 1'b0;
		axi_rd(IDX_CNT_LO, d, r);
		rd_chk(IDX_STATUS, 8'h00, "clr_status");
		chk("irq_low", 8'h00, {7'h00, timer_irq});
	endtask : t_overflow

	task automatic t_compare;
		for (int n = 0; n < 400 && compare_pin !== 1'b1; n++) @(posedge ref_clk);
		chk("compare_pin", 8'h01, {7'h00, compare_pin});
		// The watcher counts the rise one edge after the pin moves
		@(posedge ref_clk);
		chk("cmp_rises", 8'h01, cmp_rise_cnt);
		chk("irq_masked", 8'h00, {7'h00, timer_irq});
		rd_chk(IDX_CMP_LO, 8'h40, "cmp_lo");
		rd_chk(IDX_STATUS, 8'h40, "cmp_status");
		rd_chk(IDX_CMP_LO, 8'h40, "cmp_lo");
		rd_chk(IDX_STATUS, 8'h00, "cmp_clr");
	endtask : t_compare

	task automatic t_capture;
		logic [7:0] d;
		logic [1:0] r;
		axi_wr(IDX_CTRL, 8'h10);
		u_pin.drive_level(1'b1);
		rd_chk(IDX_STATUS, 8'h00, "fall_sel");
		axi_wr(IDX_CTRL, 8'h12);
		u_pin.drive_level(1'b0);
		rd_chk(IDX_STATUS, 8'h00, "rise_sel");
		u_pin.drive_level(1'b1);
		rd_chk(IDX_STATUS, 8'h80, "cap_status");
		rd_chk(IDX_CAP_HI, 8'h00, "cap_hi");
		axi_rd(IDX_CAP_LO, d, r);
		rd_chk(IDX_STATUS, 8'h00, "cap_clr");
	endtask : t_capture

	task automatic t_stop;
		logic [7:0] a, b;
		logic [1:0] r;
		@(posedge ref_clk);
		stop_mode <= 1'b1;
		axi_rd(IDX_CNT_LO, a, r);
		repeat (12) @(posedge ref_clk);
		axi_rd(IDX_CNT_LO, b, r);
		chk("stop_hold", a, b);
		u_pin.drive_level(1'b0);
		u_pin.drive_level(1'b1);
		rd_chk(IDX_STATUS, 8'h00, "stop_status");
		@(posedge ref_clk);
		stop_mode <= 1'b0;
		rd_chk(IDX_STATUS, 8'h80, "wake_status");
		axi_rd(IDX_CNT_LO, b, r);
		chk("resume", 8'h01, {7'h00, (b >= a) && (b - a < 8'h08)});
		// Edge in stop, then reset ends stop: nothing may survive
		@(posedge ref_clk);
		stop_mode <= 1'b1;
		u_pin.drive_level(1'b0);
		u_pin.drive_level(1'b1);
		reset_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		stop_mode <= 1'b0;
		reset_n <= 1'b1;
		rd_chk(IDX_STATUS, 8'h00, "rst_status");
		rd_chk(IDX_CAP_LO, 8'h00, "rst_cap_lo");
		rd_chk(IDX_CNT_HI, 8'hFF, "rst_cnt_hi");
		rd_chk(IDX_CNT_LO, 8'hFC, "rst_cnt_lo");
	endtask : t_stop

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		reset_n = 1'b0;
		wait_mode = 1'b0;
		stop_mode = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'h1;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset();
		t_overflow();
		t_compare();
		t_capture();
		t_stop();
		finish_test();
	end

endmodule : capture_compare_timer_ctrl_tb

`default_nettype wire
